// file: rtl/ost_pkg.sv
// Package: register map, field layout, reset values and states of the settle timer
package ost_pkg;

  // ************************************************************
  // Register addresses and reset values
  // ************************************************************
  localparam logic [15:0] OST_ADDR_STATUS = 16'hFFA3;
  localparam logic [15:0] OST_ADDR_SELECT = 16'hFFA4;
  localparam logic [15:0] OST_ADDR_MOC    = 16'hFFA2;
  localparam logic [15:0] OST_ADDR_MCM    = 16'hFFA1;
  localparam logic [15:0] OST_ADDR_WAIT   = 16'hFFAA;
  localparam logic [7:0]  OST_RST_STATUS  = 8'h00;
  localparam logic [7:0]  OST_RST_SELECT  = 8'h05;
  localparam logic [7:0]  OST_RST_WAIT    = 8'h00;
  localparam logic [7:0]  OST_RST_MOC     = 8'h00;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int OST_SEL_W       = 3;
  localparam int OST_WAIT_BIT    = 1;
  localparam int OST_HALT_BIT    = 7;
  localparam int OST_MCS_BIT     = 1;
  localparam int OST_MCM0_BIT    = 0;
  localparam int OST_CNT_W       = 17;

  // ************************************************************
  // Select codes and thresholds in crystal cycles
  // ************************************************************
  localparam logic [2:0] OST_SEL_2P11 = 3'h1;
  localparam logic [2:0] OST_SEL_2P13 = 3'h2;
  localparam logic [2:0] OST_SEL_2P14 = 3'h3;
  localparam logic [2:0] OST_SEL_2P15 = 3'h4;
  localparam logic [2:0] OST_SEL_2P16 = 3'h5;
  localparam logic [16:0] OST_TH_2P11 = 17'h00800;
  localparam logic [16:0] OST_TH_2P13 = 17'h02000;
  localparam logic [16:0] OST_TH_2P14 = 17'h04000;
  localparam logic [16:0] OST_TH_2P15 = 17'h08000;
  localparam logic [16:0] OST_TH_2P16 = 17'h10000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        bit_en;
    logic [2:0]  bit_pos;
  } ost_bus_t;

  typedef enum logic [2:0] {
    OST_RUN  = 3'b001,
    OST_STOP = 3'b010,
    OST_WAIT = 3'b100
  } ost_state_t;

endpackage

// file: rtl/ost_timer.sv
// Crystal oscillation settle timer with status, select, oscillator and wait registers
`timescale 1ns/100ps
`default_nettype none

module ost_timer
  import ost_pkg::*;
(
  // Clock and reset
  input  wire logic           ref_clk,
  input  wire logic           resetn,
  // Register access
  input  wire ost_pkg::ost_bus_t bus,
  output logic [7:0]          rdata,
  // Power-mode events
  input  wire logic           stop_exec,
  input  wire logic           stop_release,
  input  wire logic           other_reset,
  // Crystal oscillator
  input  wire logic           crystal_input,
  input  wire logic           osc_running,
  input  wire logic           hs_is_crystal,
  output logic                hs_osc_halt,
  // CPU side
  output logic                cpu_clock_source_status,
  output logic                cpu_hold,
  output logic                periph_wait2
);
  import ost_pkg::*;

  // ************************************************************
  // Registers and decode signals
  // ************************************************************
  logic [OST_CNT_W-1:0] cnt_q;
  logic [7:0]           sel_q;
  logic [7:0]           wait_q;
  logic                 halt_q;
  logic                 mcm0_q;
  logic                 mcs_q;
  logic                 xin_q;
  ost_state_t           state_q;
  logic [4:0]           flags;
  logic                 clr;
  logic                 xedge;
  logic [16:0]          limit;
  // Next values of the registers above
  logic [OST_CNT_W-1:0] cnt_d;
  ost_state_t           state_d;
  logic [7:0]           rdata_d;

  // Selected limit; prohibited codes fall back to the longest wait
  function automatic logic [16:0] sel_limit(input logic [2:0] s);
    case (s)
      OST_SEL_2P11: sel_limit = OST_TH_2P11;
      OST_SEL_2P13: sel_limit = OST_TH_2P13;
      OST_SEL_2P14: sel_limit = OST_TH_2P14;
      OST_SEL_2P15: sel_limit = OST_TH_2P15;
      default:      sel_limit = OST_TH_2P16;
    endcase
  endfunction

  function automatic logic reg_write(input ost_bus_t b, input logic [15:0] a);
    reg_write = b.wr && (b.addr == a);
  endfunction

  // Bit writes change only the addressed bit
  function automatic logic [7:0] merge(input ost_bus_t b, input logic [7:0] old);
    logic [7:0] v;
    v = old;
    if (b.bit_en) begin
      v[b.bit_pos] = b.wdata[b.bit_pos];
    end else begin
      v = b.wdata;
    end
    merge = v;
  endfunction

  wire logic wr_moc = reg_write(bus, OST_ADDR_MOC);
  wire logic [7:0] moc_new = merge(bus, {halt_q, 7'h00});
  wire logic [7:0] mcm_new = merge(bus, {6'h00, mcs_q, mcm0_q});

  assign limit = sel_limit(sel_q[OST_SEL_W-1:0]);
  // Crystal sampled as a synchronous input; rising edges are counted
  assign xedge = crystal_input && !xin_q && osc_running && !halt_q;
  // Edges seen while halted or before oscillation are dropped, not deferred

  // ************************************************************
  // Clearing events
  // ************************************************************
  // Halt held at 1 keeps the count at zero, so status reads 00H throughout
  always_comb begin
    clr = 1'b0;
    if (stop_exec || other_reset) begin
      clr = 1'b1;
    end
    if (wr_moc && moc_new[OST_HALT_BIT]) begin
      clr = 1'b1;
    end
    if (halt_q) begin
      clr = 1'b1;
    end
  end

  // ************************************************************
  // Crystal cycle counter
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      xin_q <= 1'b0;
    end else begin
      xin_q <= crystal_input;
    end
  end

  // Clear wins over a crystal edge in the same cycle
  always_comb begin
    cnt_d = cnt_q;
    if (clr) begin
      cnt_d = '0;
    end else if (xedge && (cnt_q < limit)) begin
      cnt_d = cnt_q + 17'h00001;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Thermometer decode keeps flags ordered and sticky until cleared
  assign flags = {cnt_q >= OST_TH_2P11, cnt_q >= OST_TH_2P13, cnt_q >= OST_TH_2P14,
                  cnt_q >= OST_TH_2P15, cnt_q >= OST_TH_2P16};

  // ************************************************************
  // Register writes
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sel_q <= OST_RST_SELECT;
    end else if (reg_write(bus, OST_ADDR_SELECT)) begin
      sel_q <= {5'h00, bus.wdata[OST_SEL_W-1:0]};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wait_q <= OST_RST_WAIT;
    end else if (reg_write(bus, OST_ADDR_WAIT)) begin
      wait_q <= merge(bus, wait_q);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      halt_q <= OST_RST_MOC[OST_HALT_BIT];
    end else if (wr_moc) begin
      halt_q <= moc_new[OST_HALT_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mcm0_q <= 1'b0;
      mcs_q  <= 1'b0;
    end else begin
      if (reg_write(bus, OST_ADDR_MCM)) begin
        // Only the select bit is taken; the status bit is read-only
        mcm0_q <= mcm_new[OST_MCM0_BIT];
      end
      // Switch takes effect only while the high-speed clock runs
      mcs_q <= mcm0_q && !halt_q;
    end
  end

  // ************************************************************
  // STOP release sequencing
  // ************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      OST_RUN: begin
        if (stop_exec) begin
          state_d = OST_STOP;
        end
      end
      OST_STOP: begin
        if (stop_release) begin
          // Low-speed CPU clock resumes at once; software polls status
          if (mcs_q && hs_is_crystal) begin
            state_d = OST_WAIT;
          end else begin
            state_d = OST_RUN;
          end
        end
      end
      OST_WAIT: begin
        // Select must not change here, or the wait ends early
        if (cnt_q >= limit) begin
          state_d = OST_RUN;
        end
      end
      default: begin
        state_d = OST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= OST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // Outputs and read data
  // ************************************************************
  // Each port leaves a flip-flop, one cycle behind the state it shows
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_hold <= 1'b0;
    end else begin
      cpu_hold <= (state_q != OST_RUN);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hs_osc_halt <= 1'b0;
    end else begin
      hs_osc_halt <= halt_q;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cpu_clock_source_status <= 1'b0;
    end else begin
      cpu_clock_source_status <= mcs_q;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      periph_wait2 <= 1'b0;
    end else begin
      periph_wait2 <= wait_q[OST_WAIT_BIT];
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  // Unmapped addresses read back as zero
  always_comb begin
    case (bus.addr)
      OST_ADDR_STATUS: rdata_d = {3'h0, flags};
      OST_ADDR_SELECT: rdata_d = sel_q;
      OST_ADDR_WAIT:   rdata_d = wait_q;
      OST_ADDR_MOC:    rdata_d = {halt_q, 7'h00};
      OST_ADDR_MCM:    rdata_d = {6'h00, mcs_q, mcm0_q};
      default:         rdata_d = 8'h00;
    endcase
  end

  // Read data stands until the next read strobe
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (bus.rd) begin
      rdata <= rdata_d;
    end
  end

endmodule

`default_nettype wire

// file: sim/ost_timer_monitor.sv
// Port checker for the crystal settle timer
`timescale 1ns/100ps
`default_nettype none
module ost_timer_monitor
  import ost_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              resetn,
  // Register access
  input wire ost_pkg::ost_bus_t bus,
  input wire logic [7:0]        rdata,
  // Events, oscillator and CPU-side outputs
  input wire logic              stop_exec,
  input wire logic              stop_release,
  input wire logic              other_reset,
  input wire logic              crystal_input,
  input wire logic              osc_running,
  input wire logic              hs_is_crystal,
  input wire logic              hs_osc_halt,
  input wire logic              cpu_clock_source_status,
  input wire logic              cpu_hold,
  input wire logic              periph_wait2
);
  import ost_pkg::*;
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic rd_st;
  logic wr_moc;
  assign rd_st  = bus.rd && !bus.bit_en && bus.addr == OST_ADDR_STATUS;
  assign wr_moc = bus.wr && bus.addr == OST_ADDR_MOC;

  chk_reset_outputs_low: assert property ($rose(resetn) |-> !hs_osc_halt && !periph_wait2)
    else $error("outputs not clear after reset");
  chk_halt_follows_write: assert property (wr_moc && !bus.bit_en
    |-> ##2 hs_osc_halt == $past(bus.wdata[7], 2))
    else $error("halt bit did not follow write");
  chk_halt_holds: assert property (!wr_moc && !other_reset |-> ##2 $stable(hs_osc_halt))
    else $error("halt bit changed without write");
  chk_wait_follows_write: assert property (bus.wr && !bus.bit_en && bus.addr == OST_ADDR_WAIT
    |-> ##2 periph_wait2 == $past(bus.wdata[1], 2))
    else $error("wait bit did not follow write");
  chk_wait_holds: assert property (!bus.wr && !other_reset |-> ##2 $stable(periph_wait2))
    else $error("wait bit changed without write");
  chk_hold_after_stop: assert property (stop_exec && !cpu_hold |-> ##2 cpu_hold)
    else $error("cpu not held after stop");
  chk_status_upper_zero: assert property (rd_st |=> rdata[7:5] == 3'h0)
    else $error("status upper bits not zero");
  chk_flag_order: assert property (rd_st |=> rdata[4:0] inside {5'h00, 5'h10, 5'h18, 5'h1C, 5'h1E, 5'h1F})
    else $error("status flags out of order");
  chk_select_upper_zero: assert property (bus.rd && bus.addr == OST_ADDR_SELECT |=> rdata[7:3] == 5'h00)
    else $error("select upper bits not zero");
  chk_stop_clears: assert property (stop_exec ##[1:4] rd_st |=> rdata[4:0] == 5'h00)
    else $error("status not cleared by stop");
  chk_halt_clears: assert property (hs_osc_halt && rd_st |=> rdata[4:0] == 5'h00)
    else $error("status not cleared by halt");
  cover property (stop_exec);
  cover property (rd_st ##1 rdata[4:0] == 5'h18);
  cover property ($rose(hs_osc_halt));
  cover property (stop_release && hs_is_crystal ##1 cpu_hold);
endmodule
bind ost_timer ost_timer_monitor u_mon (.ref_clk(ref_clk), .resetn(resetn), .bus(bus), .rdata(rdata),
  .stop_exec(stop_exec), .stop_release(stop_release), .other_reset(other_reset),
  .crystal_input(crystal_input), .osc_running(osc_running), .hs_is_crystal(hs_is_crystal),
  .hs_osc_halt(hs_osc_halt), .cpu_clock_source_status(cpu_clock_source_status),
  .cpu_hold(cpu_hold), .periph_wait2(periph_wait2));
`default_nettype wire

// file: sim/tb_top.sv
// Register-level testbench for the crystal settle timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, e); end end
module tb_top;
  import ost_pkg::*;
  logic              ref_clk = 1'b0;
  logic              resetn = 1'b0;
  ost_bus_t          bus = '0;
  logic [7:0]        rdata;
  logic              stop_exec = 1'b0, stop_release = 1'b0, other_reset = 1'b0;
  logic              crystal_input = 1'b0, osc_running = 1'b0, xtal_on = 1'b0;
  logic              hs_osc_halt, cpu_hold, periph_wait2;
  logic              hs_is_crystal = 1'b0, cpu_clock_source_status;
  int                failures = 0, n_checks = 0;

  always #5 ref_clk = ~ref_clk;
  // Crystal at half the reference rate, one count per two cycles
  always @(posedge ref_clk) if (xtal_on) crystal_input <= ~crystal_input;

  ost_timer uut (.ref_clk(ref_clk), .resetn(resetn), .bus(bus), .rdata(rdata),
    .stop_exec(stop_exec), .stop_release(stop_release), .other_reset(other_reset),
    .crystal_input(crystal_input), .osc_running(osc_running), .hs_is_crystal(hs_is_crystal),
    .hs_osc_halt(hs_osc_halt), .cpu_clock_source_status(cpu_clock_source_status),
    .cpu_hold(cpu_hold),
    .periph_wait2(periph_wait2));

  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic be);
    @(posedge ref_clk);
    bus.wr <= 1'b1; bus.addr <= a; bus.wdata <= d; bus.bit_en <= be; bus.bit_pos <= 3'h1;
    @(posedge ref_clk);
    bus.wr <= 1'b0; bus.bit_en <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus.rd <= 1'b1; bus.addr <= a;
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(posedge ref_clk);
    `CHK(rdata, e)
  endtask
  // One-cycle event: 0 stop_exec, 1 stop_release, 2 other_reset
  task automatic pulse(input int k);
    @(posedge ref_clk);
    stop_exec <= (k == 0);
    stop_release <= (k == 1);
    other_reset <= (k == 2);
    @(posedge ref_clk);
    stop_exec <= 1'b0;
    stop_release <= 1'b0;
    other_reset <= 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ************************************************************
  // Sequence
  // ************************************************************
  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(OST_ADDR_STATUS, 8'h00);
    rd(OST_ADDR_SELECT, 8'h05);
    rd(OST_ADDR_WAIT, 8'h00);
    rd(16'h0010, 8'h00);
    wr(OST_ADDR_SELECT, 8'hFA, 1'b0);
    rd(OST_ADDR_SELECT, 8'h02);
    wr(OST_ADDR_STATUS, 8'hFF, 1'b0);
    rd(OST_ADDR_STATUS, 8'h00);
    wr(OST_ADDR_WAIT, 8'h03, 1'b1);
    rd(OST_ADDR_WAIT, 8'h02);
    `CHK(periph_wait2, 1'b1)
    wr(OST_ADDR_WAIT, 8'h00, 1'b0);
    // Edges before oscillation starts must not count
    xtal_on <= 1'b1;
    repeat (5000) @(posedge ref_clk);
    rd(OST_ADDR_STATUS, 8'h00);
    osc_running <= 1'b1;
    repeat (3900) @(posedge ref_clk);
    rd(OST_ADDR_STATUS, 8'h00);
    repeat (300) @(posedge ref_clk);
    rd(OST_ADDR_STATUS, 8'h10);
    repeat (12400) @(posedge ref_clk);
    rd(OST_ADDR_STATUS, 8'h18);
    repeat (8000) @(posedge ref_clk);
    rd(OST_ADDR_STATUS, 8'h18);
    pulse(0);
    rd(OST_ADDR_STATUS, 8'h00);
    `CHK(cpu_hold, 1'b1)
    pulse(1);
    repeat (2) @(posedge ref_clk);
    `CHK(cpu_hold, 1'b0)
    wr(OST_ADDR_MOC, 8'h80, 1'b0);
    repeat (2) @(posedge ref_clk);
    `CHK(hs_osc_halt, 1'b1)
    repeat (5000) @(posedge ref_clk);
    rd(OST_ADDR_STATUS, 8'h00);
    wr(OST_ADDR_MOC, 8'h00, 1'b0);
    repeat (4400) @(posedge ref_clk);
    rd(OST_ADDR_STATUS, 8'h10);
    wr(OST_ADDR_MCM, 8'h01, 1'b0);
    rd(OST_ADDR_MCM, 8'h03);
    `CHK(cpu_clock_source_status, 1'b1)
    // Internal high-speed source: no hardware wait after release
    pulse(0);
    pulse(1);
    repeat (2) @(posedge ref_clk);
    `CHK(cpu_hold, 1'b0)
    // Crystal source: held until the selected 2^13 count is reached
    hs_is_crystal <= 1'b1;
    wr(OST_ADDR_SELECT, 8'h02, 1'b0);
    pulse(0);
    pulse(1);
    repeat (16000) @(posedge ref_clk);
    `CHK(cpu_hold, 1'b1)
    repeat (800) @(posedge ref_clk);
    `CHK(cpu_hold, 1'b0)
    rd(OST_ADDR_STATUS, 8'h18);
    pulse(2);
    rd(OST_ADDR_STATUS, 8'h00);
    complete_run;
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    failures++;
    complete_run;
  end
endmodule
`default_nettype wire
